// *** dv/ussig_irq_line.sv ***
/*
 * Shared interrupt wire seen by the host: open drain with a pull-up.
 * Assumes the block's drive value and enable as its only drivers.
 */
`timescale 1ns/100ps
module ussig_irq_line (
   // From the block
   input  wire logic int_n_level,
   input  wire logic int_n_oe,
   // Host view
   output logic      int_line_n
);
   // Released line floats to the pull-up, never the last driven level
   assign int_line_n = int_n_oe ? int_n_level : 1'b1;
endmodule

// *** dv/ussig_sva.sv ***
/*
 * Checker for ussig_top: read data against live status inputs and the
 * shared interrupt gather. Assumes aligned register addresses.
 */
`timescale 1ns/100ps
module ussig_sva #(
   parameter int NUM_CH  = ussig_pkg::NUM_CH,
   parameter int NUM_MIO = ussig_pkg::NUM_MIO
) (
   // Clock, reset, register port
   input wire logic                  CLK_SYS,
   input wire logic                  RST,
   input wire logic [7:0]            REG_ADDR,
   input wire logic                  REG_RD,
   input wire logic [31:0]           REG_RDATA,
   input wire logic                  REG_RVALID,
   // Status inputs
   input wire logic [NUM_CH*8-1:0]   RX_FILL,
   input wire logic [NUM_CH*8-1:0]   TX_FILL,
   input wire logic [NUM_CH*6-1:0]   ISR_CODE,
   input wire logic [NUM_CH-1:0]     LSR_ERR_SUM,
   input wire logic [NUM_CH-1:0]     LSR_OVERRUN,
   input wire logic [NUM_MIO-1:0]    MIO_PIN,
   input wire logic [NUM_MIO-1:0]    PIN_POLARITY,
   input wire logic [1:0]            PIN1_FUNC,
   input wire logic                  PP_IRQ,
   // Interrupt pin
   input wire logic                  INT_N_LEVEL,
   input wire logic                  INT_N_OE
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   logic [NUM_CH-1:0] gd;
   logic [NUM_CH-1:0] pend;
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         gd[i] = (ISR_CODE[6*i+:6] inside {6'h01, 6'h04, 6'h0c, 6'h02})
                 && !LSR_ERR_SUM[i] && !LSR_OVERRUN[i];
         pend[i] = !ISR_CODE[6*i];
      end
   end
   wire rd_rx  = REG_RD && REG_ADDR == ussig_pkg::OFS_RX_LEVEL;
   wire rd_tx  = REG_RD && REG_ADDR == ussig_pkg::OFS_TX_LEVEL;
   wire rd_src = REG_RD && REG_ADDR == ussig_pkg::OFS_SOURCE;
   wire rd_gis = REG_RD && REG_ADDR == ussig_pkg::OFS_GLOBAL;
   wire rd_bad = REG_RD && !(REG_ADDR[7:2] inside {6'h4, 6'h5, 6'h6, 6'h7});
   // Power-down flag is forced low with pin-1 function zero, so it cannot hold the line
   wire quiet  = !pend && !(MIO_PIN ^ PIN_POLARITY) && !PP_IRQ && PIN1_FUNC == 2'h0;
   property p_rvalid; 1 |=> REG_RVALID == $past(REG_RD); endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");
   property p_rx; rd_rx |=> REG_RDATA == $past(RX_FILL, 2); endproperty
   a_rx: assert property (p_rx) else $error("rx level word wrong");
   property p_tx; rd_tx |=> REG_RDATA == $past(TX_FILL, 2); endproperty
   a_tx: assert property (p_tx) else $error("tx level word wrong");
   property p_src; rd_src |=> REG_RDATA[26:0] == {3'h0, $past(ISR_CODE, 2)}; endproperty
   a_src: assert property (p_src) else $error("source codes wrong");
   property p_gd; rd_src |=> REG_RDATA[30:27] == $past(gd, 2); endproperty
   a_gd: assert property (p_gd) else $error("good data flags wrong");
   property p_gand; rd_src |=> REG_RDATA[31] == &REG_RDATA[30:27]; endproperty
   a_gand: assert property (p_gand) else $error("global good data wrong");
   property p_chirq; rd_gis |=> REG_RDATA[3:0] == $past(pend, 2); endproperty
   a_chirq: assert property (p_chirq) else $error("channel interrupt bits wrong");
   property p_unmap; rd_bad |=> REG_RDATA == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_odrain; INT_N_OE |-> INT_N_LEVEL == 1'b0; endproperty
   a_odrain: assert property (p_odrain) else $error("interrupt drive not low");
   property p_quiet; quiet [*2] |=> !INT_N_OE; endproperty
   a_quiet: assert property (p_quiet) else $error("interrupt with no source");
   c_burst: cover property (rd_rx ##1 rd_tx ##1 rd_src ##1 rd_gis);
   c_irq: cover property ($rose(INT_N_OE));
   c_pwr: cover property (rd_gis ##1 REG_RDATA[5]);
endmodule
bind ussig_top ussig_sva #(.NUM_CH(NUM_CH), .NUM_MIO(NUM_MIO)) u_sva (.CLK_SYS, .RST,
   .REG_ADDR, .REG_RD, .REG_RDATA, .REG_RVALID, .RX_FILL, .TX_FILL, .ISR_CODE,
   .LSR_ERR_SUM, .LSR_OVERRUN, .MIO_PIN, .PIN_POLARITY, .PIN1_FUNC, .PP_IRQ,
   .INT_N_LEVEL, .INT_N_OE);

// *** dv/ussig_top_test.sv ***
/*
 * Self-checking bench for ussig_top: register reads and writes on the
 * register port, status and pins driven directly, host line modelled.
 */
`timescale 1ns/100ps
module ussig_top_test;
   logic        CLK_SYS, RST, REG_RD, REG_WR, PP_IRQ, PWRDN_REQ, REG_RVALID;
   logic        INT_N_LEVEL, INT_N_OE, int_line_n;
   logic [7:0]  REG_ADDR;
   logic [3:0]  REG_BE, LSR_ERR_SUM, LSR_OVERRUN;
   logic [31:0] REG_WDATA, REG_RDATA, RX_FILL, TX_FILL;
   logic [23:0] ISR_CODE;
   logic [11:0] MIO_PIN, PIN_POLARITY;
   logic [2:0]  DEV_MODE;
   logic [1:0]  PIN1_FUNC;
   int          miscompares = 0;
   int          cmp_count = 0;
   logic [5:0]  codes [6] = '{6'h01, 6'h04, 6'h0c, 6'h02, 6'h06, 6'h00};
   ussig_top u_dut (.CLK_SYS, .RST, .REG_ADDR, .REG_RD, .REG_WR, .REG_BE, .REG_WDATA,
      .REG_RDATA, .REG_RVALID, .RX_FILL, .TX_FILL, .ISR_CODE, .LSR_ERR_SUM, .LSR_OVERRUN,
      .MIO_PIN, .PIN_POLARITY, .DEV_MODE, .PIN1_FUNC, .PP_IRQ, .PWRDN_REQ, .INT_N_LEVEL,
      .INT_N_OE);
   ussig_irq_line u_line (.int_n_level(INT_N_LEVEL), .int_n_oe(INT_N_OE), .int_line_n);
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge CLK_SYS);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD <= 1'b0;
      #1;
      chk("read valid", {31'h0, REG_RVALID}, 32'h1);
      chk("read data", REG_RDATA, exp);
   endtask
   task automatic burst(input logic [127:0] e);
      for (int i = 0; i < 5; i++) begin
         @(posedge CLK_SYS);
         REG_RD <= i < 4;
         REG_ADDR <= 8'h10 + 8'(4 * i);
         #1;
         if (i > 0) chk("burst data", REG_RDATA, e[128-32*i+:32]);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge CLK_SYS);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_BE <= be;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR <= 1'b0;
   endtask
   // Two edges from input or enable to the pin, one more for margin
   task automatic line(input logic exp);
      repeat (3) @(posedge CLK_SYS);
      #1;
      chk("interrupt line", {31'h0, int_line_n}, {31'h0, exp});
   endtask
   task automatic tally_and_finish();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      CLK_SYS = 1'b0;
      forever #25 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {RST, REG_RD, REG_WR, PP_IRQ, PWRDN_REQ} = 5'h10;
      {REG_ADDR, REG_BE, REG_WDATA, RX_FILL, TX_FILL} = '0;
      {LSR_ERR_SUM, LSR_OVERRUN, MIO_PIN, PIN_POLARITY, DEV_MODE, PIN1_FUNC} = '0;
      ISR_CODE = 24'h041041;
      repeat (6) @(posedge CLK_SYS);
      RST <= 1'b0;
      burst({64'h0, 32'hf8041041, 32'hffff0000});
      line(1'b1);
      RX_FILL <= 32'h80ff0102;
      TX_FILL <= 32'h7f000180;
      wr(8'h10, 4'hf, 32'h0);
      burst({64'h80ff01027f000180, 32'hf8041041, 32'hffff0000});
      for (int k = 0; k < 6; k++) begin
         ISR_CODE <= {4{codes[k]}};
         LSR_ERR_SUM <= 4'h1;
         LSR_OVERRUN <= 4'h2;
         rd(8'h18, {1'b0, k < 4 ? 4'hc : 4'h0, 3'h0, {4{codes[k]}}});
         rd(8'h1c, {16'hffff, 12'h0, {4{~codes[k][0]}}});
         line(codes[k][0]);
      end
      ISR_CODE <= {6'h04, 6'h0c, 6'h02, 6'h01};
      LSR_ERR_SUM <= 4'h0;
      LSR_OVERRUN <= 4'h0;
      rd(8'h18, {5'h1f, 3'h0, 6'h04, 6'h0c, 6'h02, 6'h01});
      wr(8'h1c, 4'h4, 32'h0);
      line(1'b1);
      // Top lane keeps pins 11..4 enabled; low half of the data must be ignored
      wr(8'h1c, 4'hf, 32'hff02ffff);
      rd(8'h1c, 32'hff02000e);
      line(1'b0);
      ISR_CODE <= 24'h041041;
      MIO_PIN <= 12'ha5c;
      PIN_POLARITY <= 12'h0f0;
      rd(8'h1c, 32'hff02aac0);
      line(1'b0);
      DEV_MODE <= 3'h2;
      line(1'b1);
      DEV_MODE <= 3'h0;
      MIO_PIN <= 12'h0f3;
      wr(8'h1c, 4'h4, 32'h00100000);
      line(1'b0);
      rd(8'h1c, 32'hff100030);
      for (int k = 0; k < 4; k++) begin
         DEV_MODE <= k[1] ? 3'h5 : 3'h1;
         PP_IRQ <= k[0];
         rd(8'h1c, {16'hff10, 10'h0, 1'b1, k[0], 4'h0});
         line(~k[0]);
      end
      DEV_MODE <= 3'h0;
      PP_IRQ <= 1'b0;
      wr(8'h1c, 4'h4, 32'h00200000);
      line(1'b0);
      PIN1_FUNC <= 2'h1;
      MIO_PIN <= 12'h0f0;
      line(1'b1);
      PWRDN_REQ <= 1'b1;
      @(posedge CLK_SYS);
      PWRDN_REQ <= 1'b0;
      line(1'b0);
      rd(8'h1c, 32'hff200020);
      rd(8'h1c, 32'hff200000);
      line(1'b1);
      // Reset in mid-run with the power-down function selected
      RST <= 1'b1;
      repeat (2) @(posedge CLK_SYS);
      RST <= 1'b0;
      rd(8'h1c, 32'hffdf0000);
      rd(8'h18, 32'hf8041041);
      rd(8'h20, 32'h0);
      tally_and_finish();
   end
endmodule

// *** hw/ussig_chan.sv ***
/*
 * One serial channel's shadow: fill levels, source code, good-data
 * flag and internal interrupt state, all registered.
 * Assumes the channel's status inputs are synchronous to CLK_SYS.
 */
`timescale 1ns/100ps
module ussig_chan (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Live channel status
   input  wire logic [7:0] rx_fill,
   input  wire logic [7:0] tx_fill,
   input  wire logic [5:0] isr_code,
   input  wire logic       lsr_err_sum,
   input  wire logic       lsr_overrun,
   // Shadowed status
   output logic      [7:0] rx_level,
   output logic      [7:0] tx_level,
   output logic      [5:0] source_code,
   output logic            good_data,
   output logic            ch_irq
);

   logic code_ok;
   logic gd_next;
   logic irq_next;

   assign code_ok  = (isr_code == ussig_pkg::ISR_NONE)   ||
                     (isr_code == ussig_pkg::ISR_RXDATA) ||
                     (isr_code == ussig_pkg::ISR_RXTMO)  ||
                     (isr_code == ussig_pkg::ISR_THRE);
   // Live error summary, so a status read that clears it lifts the flag
   assign gd_next  = code_ok & ~lsr_err_sum & ~lsr_overrun;
   assign irq_next = ~isr_code[0];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_level    <= ussig_pkg::FILL_RST;
         tx_level    <= ussig_pkg::FILL_RST;
         source_code <= ussig_pkg::ISR_RST;
         good_data   <= ussig_pkg::GD_RST;
         ch_irq      <= 1'h0;
      end else begin
         rx_level    <= rx_fill;
         tx_level    <= tx_fill;
         source_code <= isr_code;
         good_data   <= gd_next;
         ch_irq      <= irq_next;
      end
   end

endmodule

// *** hw/ussig_pkg.sv ***
/*
 * Constants for the serial status shadow and interrupt gather block:
 * register offsets, field positions, reset values, source codes, modes.
 * Assumes a 32-bit register port with byte addresses.
 */
package ussig_pkg;

   // Sizes
   localparam int NUM_CH  = 4;
   localparam int FILL_W  = 8;
   localparam int ISR_W   = 6;
   localparam int NUM_MIO = 12;

   // Register byte offsets
   localparam logic [7:0] OFS_RX_LEVEL = 8'h10;
   localparam logic [7:0] OFS_TX_LEVEL = 8'h14;
   localparam logic [7:0] OFS_SOURCE   = 8'h18;
   localparam logic [7:0] OFS_GLOBAL   = 8'h1c;

   // Source word fields
   localparam int SRC_GD_LSB  = 27;
   localparam int SRC_GGD_BIT = 31;

   // Global word fields
   localparam int GIS_CHIRQ_LSB = 0;
   localparam int GIS_B4        = 4;
   localparam int GIS_B5        = 5;
   localparam int GIS_MIO_LSB   = 6;
   localparam int GIS_CHEN_LSB  = 16;
   localparam int GIS_EN20      = 20;
   localparam int GIS_EN21      = 21;
   localparam int GIS_MIOEN_LSB = 22;

   // Reset values
   localparam logic [7:0] FILL_RST     = 8'h00;
   localparam logic [5:0] ISR_RST      = 6'h01;
   localparam logic       GD_RST       = 1'h1;
   localparam logic [3:0] CHEN_RST     = 4'hf;
   localparam logic       EN20_RST     = 1'h1;
   localparam logic       EN21_RST_PIN = 1'h1;
   localparam logic       EN21_RST_PWR = 1'h0;
   localparam logic [9:0] MIOEN_RST    = 10'h3ff;

   // Interrupt source codes that still allow good data
   localparam logic [5:0] ISR_NONE   = 6'h01;
   localparam logic [5:0] ISR_RXDATA = 6'h04;
   localparam logic [5:0] ISR_RXTMO  = 6'h0c;
   localparam logic [5:0] ISR_THRE   = 6'h02;

   // Device modes and pin-1 function
   localparam logic [2:0] MODE_PP_A = 3'h1;
   localparam logic [2:0] MODE_PP_B = 3'h5;
   localparam logic [2:0] MODE_SSID = 3'h2;
   localparam logic [1:0] PIN1_AS_PIN = 2'h0;

   // Register select
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_RX   = 3'b001,
      SEL_TX   = 3'b010,
      SEL_SRC  = 3'b011,
      SEL_GIS  = 3'b100
   } ussig_sel_t;

endpackage

// *** hw/ussig_top.sv ***
/*
 * Status shadow and interrupt gather for four serial channels and the
 * multipurpose pins: three adjacent read words, a global status and
 * enable word, and the shared level interrupt request.
 * Assumes a register port from the bus target with one-cycle strobes,
 * and all status inputs synchronous to CLK_SYS.
 */
// Function
// - Word 0x10 shows each channel's receive fill count per byte, reset zero.
// - Word 0x14 shows each channel's transmit fill count per byte, reset zero.
// - Word 0x18 mirrors four six-bit source codes, each resetting to 01h.
// - Bits 27-30 are per-channel good-data flags, bit 31 their AND, reset one.
// - Good data needs an allowed source code, no error summary, no overrun.
// - Flag follows live error summary; software drains FIFO after status read.
// - The four words sit at 10h-1Ch and may be burst read.
// - Global bits 3:0 show channel interrupt states, read-only, reset zero.
// - Outside parallel modes, bit 4 shows polarity-adjusted pin 0.
// - In parallel modes, bit 4 shows the parallel port request, reset zero.
// - With pin-1 field zero, bit 5 shows polarity-adjusted pin 1.
// - Otherwise bit 5 is sticky power-down flag, cleared by host read.
// - Bits 15:6 show polarity-adjusted pins 11 down to 2.
// - Bits 19:16 are channel interrupt enables, read-write, reset Fh.
// - Outside parallel modes, bit 20 enables pin 0 interrupt, reset one.
// - In parallel modes, bit 20 enables the parallel port interrupt.
// - With pin-1 field zero, bit 21 enables pin 1 interrupt, reset one.
// - Otherwise bit 21 enables the power-down interrupt, reset zero.
// - Bits 31:22 enable pins 11 down to 2, reset 3FFh.
// - Bits 3:0 are inverse of each channel's no-pending source bit.
// - The interrupt pin is a shareable level, low while any enabled source is active; pins are ignored in SSID mode.
`timescale 1ns/100ps
module ussig_top #(
   parameter int NUM_CH  = ussig_pkg::NUM_CH,
   parameter int NUM_MIO = ussig_pkg::NUM_MIO
) (
   // Clock and reset
   input  wire logic                        CLK_SYS,
   input  wire logic                        RST,
   // Register port
   input  wire logic [7:0]                  REG_ADDR,
   input  wire logic                        REG_RD,
   input  wire logic                        REG_WR,
   input  wire logic [3:0]                  REG_BE,
   input  wire logic [31:0]                 REG_WDATA,
   output logic      [31:0]                 REG_RDATA,
   output logic                             REG_RVALID,
   // Serial channel status
   input  wire logic [NUM_CH*8-1:0]         RX_FILL,
   input  wire logic [NUM_CH*8-1:0]         TX_FILL,
   input  wire logic [NUM_CH*6-1:0]         ISR_CODE,
   input  wire logic [NUM_CH-1:0]           LSR_ERR_SUM,
   input  wire logic [NUM_CH-1:0]           LSR_OVERRUN,
   // Multipurpose pins and configuration
   input  wire logic [NUM_MIO-1:0]          MIO_PIN,
   input  wire logic [NUM_MIO-1:0]          PIN_POLARITY,
   input  wire logic [2:0]                  DEV_MODE,
   input  wire logic [1:0]                  PIN1_FUNC,
   // Other sources
   input  wire logic                        PP_IRQ,
   input  wire logic                        PWRDN_REQ,
   // Interrupt pin, open drain
   output logic                             INT_N_LEVEL,
   output logic                             INT_N_OE
);

   // Shadow buses
   logic [31:0]           rx_word;
   logic [31:0]           tx_word;
   logic [NUM_CH*6-1:0]   isr_bus;
   logic [NUM_CH-1:0]     gd_bus;
   logic [NUM_CH-1:0]     ch_irq;

   // Registers
   logic [NUM_MIO-1:0]    mio_int_reg;
   logic                  pp_irq_reg;
   logic                  pwrdn_reg;
   logic                  pwrdn_next;
   logic [3:0]            chen_reg;
   logic [3:0]            chen_next;
   logic                  en20_reg;
   logic                  en20_next;
   logic                  en21_reg;
   logic                  en21_next;
   logic [9:0]            mioen_reg;
   logic [9:0]            mioen_next;
   logic                  irq_reg;
   logic                  irq_next;
   logic [31:0]           rdata_reg;
   logic [31:0]           rdata_next;
   logic                  rvalid_reg;

   // Decode
   ussig_pkg::ussig_sel_t sel;
   logic                  rd_gis;
   logic                  wr_gis;
   logic                  wr_lo;
   logic                  wr_hi;

   // Modes
   logic                  pp_mode;
   logic                  ssid_mode;
   logic                  pin1_as_pin;

   // Assembled words
   logic [31:0]           src_word;
   logic [31:0]           gis_word;
   logic                  gis_b4;
   logic                  gis_b5;

   // Interrupt terms
   logic                  ch_term;
   logic                  b4_term;
   logic                  b5_term;
   logic                  mio_term;
   logic                  pwrdn_set;

   genvar i;

   // Per-channel shadows, packed straight into the read words
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_chan
         ussig_chan u_chan (
            .clk_sys     (CLK_SYS),
            .rst         (RST),
            .rx_fill     (RX_FILL[i*8 +: 8]),
            .tx_fill     (TX_FILL[i*8 +: 8]),
            .isr_code    (ISR_CODE[i*6 +: 6]),
            .lsr_err_sum (LSR_ERR_SUM[i]),
            .lsr_overrun (LSR_OVERRUN[i]),
            .rx_level    (rx_word[i*8 +: 8]),
            .tx_level    (tx_word[i*8 +: 8]),
            .source_code (isr_bus[i*6 +: 6]),
            .good_data   (gd_bus[i]),
            .ch_irq      (ch_irq[i])
         );
      end
   endgenerate

   // Mode decode
   assign pp_mode     = (DEV_MODE == ussig_pkg::MODE_PP_A) ||
                        (DEV_MODE == ussig_pkg::MODE_PP_B);
   // Pins that carry a subsystem code must never interrupt
   assign ssid_mode   = (DEV_MODE == ussig_pkg::MODE_SSID);
   assign pin1_as_pin = (PIN1_FUNC == ussig_pkg::PIN1_AS_PIN);

   // Address decode, word aligned; low address bits are ignored
   always_comb begin
      case (REG_ADDR[7:2])
         ussig_pkg::OFS_RX_LEVEL[7:2]: sel = ussig_pkg::SEL_RX;
         ussig_pkg::OFS_TX_LEVEL[7:2]: sel = ussig_pkg::SEL_TX;
         ussig_pkg::OFS_SOURCE[7:2]:   sel = ussig_pkg::SEL_SRC;
         ussig_pkg::OFS_GLOBAL[7:2]:   sel = ussig_pkg::SEL_GIS;
         default:                      sel = ussig_pkg::SEL_NONE;
      endcase
   end

   assign rd_gis = REG_RD & (sel == ussig_pkg::SEL_GIS);
   assign wr_gis = REG_WR & (sel == ussig_pkg::SEL_GIS);
   assign wr_lo  = wr_gis & REG_BE[2];
   assign wr_hi  = wr_gis & REG_BE[3];

   // Source word; bits 26:24 read as zero
   assign src_word[23:0]  = isr_bus;
   assign src_word[26:24] = 3'h0;
   assign src_word[30:ussig_pkg::SRC_GD_LSB] = gd_bus;
   assign src_word[ussig_pkg::SRC_GGD_BIT]   = &gd_bus;

   // Shared status bits
   assign gis_b4 = pp_mode ? pp_irq_reg : mio_int_reg[0];
   assign gis_b5 = pin1_as_pin ? mio_int_reg[1] : pwrdn_reg;

   // Global word
   assign gis_word[3:ussig_pkg::GIS_CHIRQ_LSB] = ch_irq;
   assign gis_word[ussig_pkg::GIS_B4]          = gis_b4;
   assign gis_word[ussig_pkg::GIS_B5]          = gis_b5;
   assign gis_word[15:ussig_pkg::GIS_MIO_LSB]  = mio_int_reg[11:2];
   assign gis_word[19:ussig_pkg::GIS_CHEN_LSB] = chen_reg;
   assign gis_word[ussig_pkg::GIS_EN20]        = en20_reg;
   assign gis_word[ussig_pkg::GIS_EN21]        = en21_reg;
   assign gis_word[31:ussig_pkg::GIS_MIOEN_LSB] = mioen_reg;

   // Read data; unmapped words read as zero
   always_comb begin
      case (sel)
         ussig_pkg::SEL_RX:  rdata_next = rx_word;
         ussig_pkg::SEL_TX:  rdata_next = tx_word;
         ussig_pkg::SEL_SRC: rdata_next = src_word;
         ussig_pkg::SEL_GIS: rdata_next = gis_word;
         default:            rdata_next = 32'h0000_0000;
      endcase
   end

   // Enable writes by byte lane; the status half of the word is read-only
   assign chen_next  = wr_lo ? REG_WDATA[19:16] : chen_reg;
   assign en20_next  = wr_lo ? REG_WDATA[20] : en20_reg;
   assign en21_next  = wr_lo ? REG_WDATA[21] : en21_reg;
   assign mioen_next[1:0] = wr_lo ? REG_WDATA[23:22] : mioen_reg[1:0];
   assign mioen_next[9:2] = wr_hi ? REG_WDATA[31:24] : mioen_reg[9:2];

   // Sticky power-down flag; a request in the reading cycle survives
   assign pwrdn_set  = PWRDN_REQ & ~pin1_as_pin;
   assign pwrdn_next = pwrdn_set ? 1'h1 :
                       (rd_gis | pin1_as_pin) ? 1'h0 : pwrdn_reg;

   // Interrupt gather
   assign ch_term  = |(ch_irq & chen_reg);
   assign b4_term  = pp_mode ? (pp_irq_reg & en20_reg) :
                     (mio_int_reg[0] & en20_reg & ~ssid_mode);
   assign b5_term  = pin1_as_pin ? (mio_int_reg[1] & en21_reg & ~ssid_mode) :
                     (pwrdn_reg & en21_reg);
   assign mio_term = |(mio_int_reg[11:2] & mioen_reg) & ~ssid_mode;
   assign irq_next = ch_term | b4_term | b5_term | mio_term;

   // Pin state and other source capture
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mio_int_reg <= {NUM_MIO{1'b0}};
      end else begin
         mio_int_reg <= MIO_PIN ^ PIN_POLARITY;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pp_irq_reg <= 1'h0;
      end else begin
         pp_irq_reg <= PP_IRQ;
      end
   end

   // Enables, one register to a block
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         chen_reg <= ussig_pkg::CHEN_RST;
      end else begin
         chen_reg <= chen_next;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         en20_reg <= ussig_pkg::EN20_RST;
      end else begin
         en20_reg <= en20_next;
      end
   end

   // Reset value follows the pin-1 function seen while reset is held
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         en21_reg <= pin1_as_pin ? ussig_pkg::EN21_RST_PIN :
                                   ussig_pkg::EN21_RST_PWR;
      end else begin
         en21_reg <= en21_next;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mioen_reg <= ussig_pkg::MIOEN_RST;
      end else begin
         mioen_reg <= mioen_next;
      end
   end

   // Sticky flag
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         pwrdn_reg <= 1'h0;
      end else begin
         pwrdn_reg <= pwrdn_next;
      end
   end

   // Interrupt request and read return
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_reg <= 1'h0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // Read data holds until the next read, so a slow host still sees it
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= REG_RD ? rdata_next : rdata_reg;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         rvalid_reg <= 1'h0;
      end else begin
         rvalid_reg <= REG_RD;
      end
   end

   // Drive low only while a source is active, so the line stays shareable
   assign INT_N_LEVEL = 1'h0;
   assign INT_N_OE    = irq_reg;
   assign REG_RDATA   = rdata_reg;
   assign REG_RVALID  = rvalid_reg;

endmodule
